// ---- common/debug_trigger_pkg.sv ----
package debug_trigger_pkg;

  // register indices on the plain register port
  localparam logic [2:0] CONTROL_ADDR  = 3'h0;
  localparam logic [2:0] TRIGGER_ADDR  = 3'h1;
  localparam logic [2:0] STATUS_ADDR   = 3'h2;
  localparam logic [2:0] CAP_HIGH_ADDR = 3'h3;
  localparam logic [2:0] CAP_LOW_ADDR  = 3'h4;

  // debug_control fields
  localparam int CTL_ENABLE = 7;
  localparam int CTL_ARM    = 6;
  localparam int CTL_TAG    = 5;
  localparam int CTL_BREAK  = 4;
  localparam int CTL_RWA    = 3;
  localparam int CTL_RWAEN  = 2;
  localparam int CTL_RWB    = 1;
  localparam int CTL_RWBEN  = 0;

  // trigger_config fields
  localparam int TRG_TYPE  = 7;
  localparam int TRG_BEGIN = 6;

  // debug_run_status fields
  localparam int STS_MATCH_A = 7;
  localparam int STS_MATCH_B = 6;
  localparam int STS_ARMED   = 5;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] TRIGGER_RESET = 8'h00;
  localparam logic [7:0] TRIGGER_WMASK = 8'hcf;

  // trigger_mode_field codes
  localparam logic [3:0] MODE_A_ONLY     = 4'h0;
  localparam logic [3:0] MODE_A_OR_B     = 4'h1;
  localparam logic [3:0] MODE_A_THEN_B   = 4'h2;
  localparam logic [3:0] MODE_EVENT_B    = 4'h3;
  localparam logic [3:0] MODE_A_EVENT_B  = 4'h4;
  localparam logic [3:0] MODE_A_AND_DATA = 4'h5;
  localparam logic [3:0] MODE_A_NOT_DATA = 4'h6;
  localparam logic [3:0] MODE_INSIDE     = 4'h7;
  localparam logic [3:0] MODE_OUTSIDE    = 4'h8;

  typedef struct packed {
    logic        valid;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  data;
  } cpu_access_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } code_event_t;

  typedef enum logic [1:0] {RUN_IDLE, RUN_WAIT, RUN_STORE} run_state_t;

endpackage : debug_trigger_pkg

// ---- hdl/debug_trigger_and_status.sv ----
`timescale 1ns/1ps
module debug_trigger_and_status #(
  parameter int DEPTH = 8
) (
  input  wire logic                         sys_clk,   // bus clock
  input  wire logic                         reset,     // async, active high
  input  wire logic [2:0]                   reg_addr,  // register index
  input  wire logic [7:0]                   reg_wdata, // write data
  input  wire logic                         reg_wr,    // write strobe
  input  wire logic                         reg_rd,    // read strobe
  output logic [7:0]                        reg_rdata, // read data, next cycle
  input  wire debug_trigger_pkg::cpu_access_t cpu,     // cpu bus access
  input  wire debug_trigger_pkg::code_event_t flow,    // change-of-flow address
  input  wire debug_trigger_pkg::code_event_t exec,    // executed opcode address
  input  wire logic [15:0]                  comp_a,    // comparator A value
  input  wire logic [15:0]                  comp_b,    // comparator B value
  output logic                              break_req, // cpu break pulse
  output logic                              break_tag, // break is tag type
  output logic                              run_active // debugger armed
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [3:0] FULL_COUNT = 4'(DEPTH);

  // the count field is four bits and pointers wrap by width
  generate
    if (DEPTH < 2 || DEPTH > 8 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("DEPTH must be a power of two from 2 to 8");
    end
  endgenerate

  function automatic logic is_event_only(input logic [3:0] mode);
    is_event_only = (mode == debug_trigger_pkg::MODE_EVENT_B) ||
                    (mode == debug_trigger_pkg::MODE_A_EVENT_B);
  endfunction : is_event_only

  logic [7:0]                     control;
  logic [7:0]                     trigger;
  logic                           armed;
  logic                           hit_a_flag;
  logic                           hit_b_flag;
  logic                           tag_pending;
  logic [15:0]                    tag_addr;
  logic [3:0]                     count;
  logic [PW-1:0]                  wptr;
  logic [PW-1:0]                  rptr;
  logic [15:0]                    store [DEPTH];
  debug_trigger_pkg::run_state_t  state;

  logic [3:0]  mode;
  logic        event_only;
  logic        begin_trace;
  logic        wr_control;
  logic        arm_start;
  logic        manual_stop;
  logic        a_hit;
  logic        b_hit;
  logic        data_b;
  logic        in_range;
  logic        raw_match;
  logic        tag_fire;
  logic        trigger_event;
  logic        event_store;
  logic        store_word;
  logic [15:0] store_data;
  logic        end_full;
  logic        end_trig;
  logic        stop;
  logic        next_full;
  logic [PW-1:0] next_wptr;
  logic [7:0]  status_view;

  // register strobes and run start/stop
  assign wr_control  = reg_wr && (reg_addr == debug_trigger_pkg::CONTROL_ADDR);
  assign arm_start   = wr_control && !armed && reg_wdata[debug_trigger_pkg::CTL_ARM] &&
                       reg_wdata[debug_trigger_pkg::CTL_ENABLE];
  assign manual_stop = wr_control && armed && (!reg_wdata[debug_trigger_pkg::CTL_ARM] ||
                       !reg_wdata[debug_trigger_pkg::CTL_ENABLE]);

  // mode decode
  assign mode        = trigger[3:0];
  assign event_only  = is_event_only(mode);
  assign begin_trace = trigger[debug_trigger_pkg::TRG_BEGIN] || event_only;

  // comparators, optionally qualified by read/write
  assign a_hit    = cpu.valid && (cpu.addr == comp_a) &&
                    (!control[debug_trigger_pkg::CTL_RWAEN] ||
                     (cpu.rd == control[debug_trigger_pkg::CTL_RWA]));
  assign b_hit    = cpu.valid && (cpu.addr == comp_b) &&
                    (!control[debug_trigger_pkg::CTL_RWBEN] ||
                     (cpu.rd == control[debug_trigger_pkg::CTL_RWB]));
  assign data_b   = cpu.data == comp_b[7:0];
  assign in_range = (cpu.addr >= comp_a) && (cpu.addr <= comp_b);

  // raw trigger condition per mode
  always_comb begin
    raw_match = 1'b0;
    case (mode)
      debug_trigger_pkg::MODE_A_ONLY:     raw_match = a_hit;
      debug_trigger_pkg::MODE_A_OR_B:     raw_match = a_hit || b_hit;
      debug_trigger_pkg::MODE_A_THEN_B:   raw_match = hit_a_flag && b_hit;
      debug_trigger_pkg::MODE_A_AND_DATA: raw_match = a_hit && data_b;
      debug_trigger_pkg::MODE_A_NOT_DATA: raw_match = a_hit && !data_b;
      debug_trigger_pkg::MODE_INSIDE:     raw_match = cpu.valid && in_range;
      debug_trigger_pkg::MODE_OUTSIDE:    raw_match = cpu.valid && !in_range;
      default:                            raw_match = 1'b0;
    endcase
  end

  // tag waits for execution of the matched opcode; force fires at once
  assign tag_fire      = tag_pending && exec.valid && (exec.addr == tag_addr);
  assign trigger_event = armed && !event_only &&
                         (trigger[debug_trigger_pkg::TRG_TYPE] ? tag_fire : raw_match);

  // event-only modes store the data byte of each qualifying B access
  assign event_store = b_hit && ((mode == debug_trigger_pkg::MODE_EVENT_B) ||
                       hit_a_flag);
  assign store_word  = armed && (state == debug_trigger_pkg::RUN_STORE) &&
                       (event_only ? event_store : flow.valid);
  assign store_data  = event_only ? {8'h00, cpu.data} : flow.addr;

  // run end conditions
  assign end_full = store_word && begin_trace && (count == FULL_COUNT - 4'h1);
  assign end_trig = trigger_event && !begin_trace &&
                    (state == debug_trigger_pkg::RUN_STORE);
  assign stop     = (armed && (end_full || end_trig)) || manual_stop;

  assign next_wptr = wptr + {{(PW-1){1'b0}}, store_word};
  assign next_full = (count == FULL_COUNT) || (store_word && (count == FULL_COUNT - 4'h1));

  // control register; arm bit reads back the live armed state
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      control <= debug_trigger_pkg::CONTROL_RESET;
    end else if (wr_control) begin
      control <= reg_wdata;
    end
  end

  // trigger configuration locked while armed
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      trigger <= debug_trigger_pkg::TRIGGER_RESET;
    end else if (reg_wr && reg_addr == debug_trigger_pkg::TRIGGER_ADDR && !armed) begin
      trigger <= reg_wdata & debug_trigger_pkg::TRIGGER_WMASK;
    end
  end

  // armed state; start and stop are exclusive by construction
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      armed <= 1'b0;
    end else if (arm_start) begin
      armed <= 1'b1;
    end else if (stop) begin
      armed <= 1'b0;
    end
  end

  // run state machine
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state <= debug_trigger_pkg::RUN_IDLE;
    end else if (arm_start) begin
      state <= begin_trace && !event_only ? debug_trigger_pkg::RUN_WAIT
                                          : debug_trigger_pkg::RUN_STORE;
    end else if (stop) begin
      state <= debug_trigger_pkg::RUN_IDLE;
    end else begin
      case (state)
        debug_trigger_pkg::RUN_IDLE:  state <= debug_trigger_pkg::RUN_IDLE;
        debug_trigger_pkg::RUN_WAIT: begin
          if (trigger_event) begin
            state <= debug_trigger_pkg::RUN_STORE;
          end
        end
        debug_trigger_pkg::RUN_STORE: state <= debug_trigger_pkg::RUN_STORE;
        default:                      state <= debug_trigger_pkg::RUN_IDLE;
      endcase
    end
  end

  // match flags; no hit can count in the arming cycle, so no clash
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hit_a_flag <= 1'b0;
      hit_b_flag <= 1'b0;
    end else if (arm_start) begin
      hit_a_flag <= 1'b0;
      hit_b_flag <= 1'b0;
    end else if (armed) begin
      hit_a_flag <= hit_a_flag || a_hit;
      hit_b_flag <= hit_b_flag || b_hit;
    end
  end

  // tag tracking holds one pending match address at a time
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tag_pending <= 1'b0;
      tag_addr    <= 16'h0000;
    end else if (arm_start || !armed) begin
      tag_pending <= 1'b0;
    end else if (tag_fire) begin
      tag_pending <= 1'b0;
    end else if (trigger[debug_trigger_pkg::TRG_TYPE] && raw_match && !tag_pending) begin
      tag_pending <= 1'b1;
      tag_addr    <= cpu.addr;
    end
  end

  // valid count saturates at full; reads never touch it
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      count <= 4'h0;
    end else if (arm_start) begin
      count <= 4'h0;
    end else if (store_word && count != FULL_COUNT) begin
      count <= count + 4'h1;
    end
  end

  // capture store write side, circular for end trace
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wptr <= '0;
    end else if (arm_start) begin
      wptr <= '0;
    end else begin
      wptr <= next_wptr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (store_word) begin
      store[wptr] <= store_data;
    end
  end

  // read pointer lands on the oldest word at run end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rptr <= '0;
    end else if (arm_start) begin
      rptr <= '0;
    end else if (stop) begin
      rptr <= next_full ? next_wptr : '0;
    end else if (reg_rd && reg_addr == debug_trigger_pkg::CAP_LOW_ADDR && !armed) begin
      rptr <= rptr + {{(PW-1){1'b0}}, 1'b1};
    end
  end

  assign status_view = {hit_a_flag, hit_b_flag,
                        armed && control[debug_trigger_pkg::CTL_ENABLE], 1'b0, count};

  // read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        debug_trigger_pkg::CONTROL_ADDR:
          reg_rdata <= {control[7], armed, control[5:0]};
        debug_trigger_pkg::TRIGGER_ADDR:  reg_rdata <= trigger;
        debug_trigger_pkg::STATUS_ADDR:   reg_rdata <= status_view;
        debug_trigger_pkg::CAP_HIGH_ADDR: reg_rdata <= store[rptr][15:8];
        debug_trigger_pkg::CAP_LOW_ADDR:  reg_rdata <= store[rptr][7:0];
        default:                          reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // break request pulse, timing independent of trigger type
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      break_req <= 1'b0;
      break_tag <= 1'b0;
    end else begin
      break_req <= control[debug_trigger_pkg::CTL_BREAK] && armed &&
                   (begin_trace ? end_full : end_trig);
      break_tag <= control[debug_trigger_pkg::CTL_TAG];
    end
  end

  assign run_active = armed;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_trigger_locked;
    reg_wr && reg_addr == debug_trigger_pkg::TRIGGER_ADDR && armed |=> $stable(trigger);
  endproperty
  a_trigger_locked: assert property (p_trigger_locked) else $error("trigger written while armed");

  property p_status_ro;
    reg_wr && reg_addr == debug_trigger_pkg::STATUS_ADDR && !armed
      |=> $stable({hit_a_flag, hit_b_flag, count});
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status changed by write");

  property p_force_end;
    armed && !trigger[debug_trigger_pkg::TRG_TYPE] && !begin_trace && mode == 4'h0 &&
      a_hit && state == debug_trigger_pkg::RUN_STORE |=> !armed;
  endproperty
  a_force_end: assert property (p_force_end) else $error("force trigger did not end run");

  property p_tag_waits;
    armed && trigger[debug_trigger_pkg::TRG_TYPE] && !tag_pending && !manual_stop &&
      !end_full && raw_match |=> armed && tag_pending;
  endproperty
  a_tag_waits: assert property (p_tag_waits) else $error("tag match did not wait");

  property p_run_start_clears;
    arm_start |=> armed && !hit_a_flag && !hit_b_flag && count == 4'h0;
  endproperty
  a_run_start_clears: assert property (p_run_start_clears) else $error("run start not clean");

  property p_full_ends;
    armed && !manual_stop && end_full |=> !armed && count == FULL_COUNT;
  endproperty
  a_full_ends: assert property (p_full_ends) else $error("full store did not end run");

  property p_manual_stop;
    manual_stop |=> !armed && state == debug_trigger_pkg::RUN_IDLE;
  endproperty
  a_manual_stop: assert property (p_manual_stop) else $error("manual stop ignored");

  property p_low_advance;
    reg_rd && reg_addr == debug_trigger_pkg::CAP_LOW_ADDR && !armed && !arm_start
      |=> rptr == $past(rptr) + 1'b1;
  endproperty
  a_low_advance: assert property (p_low_advance) else $error("low read did not advance");

  property p_break_end;
    control[debug_trigger_pkg::CTL_BREAK] && armed && end_trig |=> break_req ##1 !break_req;
  endproperty
  a_break_end: assert property (p_break_end) else $error("end trace break missing");

  property p_no_trigger;
    mode > debug_trigger_pkg::MODE_OUTSIDE |-> !trigger_event;
  endproperty
  a_no_trigger: assert property (p_no_trigger) else $error("reserved mode triggered");

  property p_event_begin;
    arm_start && is_event_only(mode) |=> state == debug_trigger_pkg::RUN_STORE;
  endproperty
  a_event_begin: assert property (p_event_begin) else $error("event mode not begin");

endmodule : debug_trigger_and_status

// ---- dv/cpu_bus_model.sv ----
`timescale 1ns/1ps
// stand-in for the cpu bus: one access or event per call
module cpu_bus_model (
  input  wire logic                      sys_clk, // bus clock
  output debug_trigger_pkg::cpu_access_t cpu,     // cpu bus access
  output debug_trigger_pkg::code_event_t flow,    // change-of-flow address
  output debug_trigger_pkg::code_event_t exec     // executed opcode address
);
  initial begin
    cpu  = '0;
    flow = '0;
    exec = '0;
  end

  // idle lines carry inverted values so a stale address can never look valid
  task automatic acc(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cpu <= '{valid: 1'b1, rd: 1'b1, addr: a, data: d};
    @(posedge sys_clk);
    cpu <= '{valid: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
  endtask : acc

  // x high: executed opcode (tag path), low: change-of-flow word
  task automatic ev(input bit x, input logic [15:0] a);
    @(posedge sys_clk);
    if (x) exec <= '{valid: 1'b1, addr: a};
    else flow <= '{valid: 1'b1, addr: a};
    @(posedge sys_clk);
    exec <= '{valid: 1'b0, addr: ~a};
    flow <= '{valid: 1'b0, addr: ~a};
  endtask : ev
endmodule : cpu_bus_model

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic                           sys_clk;    // bus clock
  logic                           reset;      // async reset
  logic [2:0]                     reg_addr;   // register index
  logic [7:0]                     reg_wdata;  // write data
  logic                           reg_wr;     // write strobe
  logic                           reg_rd;     // read strobe
  logic [7:0]                     reg_rdata;  // read data
  debug_trigger_pkg::cpu_access_t cpu;        // cpu access
  debug_trigger_pkg::code_event_t flow;       // flow event
  debug_trigger_pkg::code_event_t exec;       // exec event
  logic [15:0]                    comp_a;     // comparator a
  logic [15:0]                    comp_b;     // comparator b
  logic                           break_req;  // break pulse
  logic                           break_tag;  // tag break
  logic                           run_active; // armed
  int                             bad_count;
  int                             tests_run;

  cpu_bus_model m (.sys_clk(sys_clk), .cpu(cpu), .flow(flow), .exec(exec));

  debug_trigger_and_status debug_trigger_and_status_i (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu(cpu), .flow(flow),
    .exec(exec), .comp_a(comp_a), .comp_b(comp_b), .break_req(break_req),
    .break_tag(break_tag), .run_active(run_active));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [7:0] got, input logic [7:0] e);
    tests_run++;
    if (got !== e) begin
      $display("Error at %0t: got %h expected %h", $time, got, e);
      bad_count++;
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rdc

  task automatic look(input logic e);
    @(posedge sys_clk);
    #1;
    chk({7'h0, run_active}, {7'h0, e});
  endtask : look

  task automatic hit(input logic [15:0] a, input logic [7:0] d, input logic e);
    m.acc(a, d);
    look(e);
  endtask : hit

  // called in the ending edge's time step; the pulse stands until the next edge
  task automatic ended();
    #1;
    chk({7'h0, run_active}, 8'h00);
    chk({7'h0, break_req}, 8'h01);
    @(posedge sys_clk);
    #1;
    chk({7'h0, break_req}, 8'h00);
  endtask : ended

  // disarm first so the trigger write is not refused
  task automatic run(input logic [7:0] t, input logic [7:0] c);
    wr(debug_trigger_pkg::CONTROL_ADDR, 8'h00);
    wr(debug_trigger_pkg::TRIGGER_ADDR, t);
    wr(debug_trigger_pkg::CONTROL_ADDR, c);
  endtask : run

  // eight stores fill the store; run must survive the first seven
  task automatic burst(input bit fl);
    for (int i = 0; i < 8; i++) begin
      if (fl) m.ev(1'b0, 16'h4000 + 16'(i));
      else m.acc(comp_b, 8'h30 + 8'(i));
      if (i < 7) look(1'b1);
    end
    ended();
  endtask : burst

  initial begin
    repeat (50000) @(posedge sys_clk);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    reset = 1'b1;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    comp_a = 16'h1000;
    comp_b = 16'h2000;
    bad_count = 0;
    tests_run = 0;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    // reset values, unmapped index, read-only status
    rdc(debug_trigger_pkg::CONTROL_ADDR, 8'h00);
    rdc(debug_trigger_pkg::TRIGGER_ADDR, 8'h00);
    rdc(3'h5, 8'h00);
    wr(debug_trigger_pkg::STATUS_ADDR, 8'hff);
    rdc(debug_trigger_pkg::STATUS_ADDR, 8'h00);
    wr(debug_trigger_pkg::TRIGGER_ADDR, 8'hff);
    rdc(debug_trigger_pkg::TRIGGER_ADDR, 8'hcf);
    @(posedge sys_clk);
    #1;
    chk(reg_rdata, 8'h00);
    $display("test registers done");
    // mode 0 force end trace with three stored words
    run(8'h00, 8'hd0);
    rdc(debug_trigger_pkg::STATUS_ADDR, 8'h20);
    wr(debug_trigger_pkg::TRIGGER_ADDR, 8'hff);
    rdc(debug_trigger_pkg::TRIGGER_ADDR, 8'h00);
    m.ev(1'b0, 16'h1111);
    m.ev(1'b0, 16'h2222);
    m.ev(1'b0, 16'h3333);
    m.acc(comp_a, 8'h00);
    ended();
    rdc(debug_trigger_pkg::STATUS_ADDR, 8'h83);
    rdc(debug_trigger_pkg::CONTROL_ADDR, 8'h90);
    rdc(debug_trigger_pkg::CAP_HIGH_ADDR, 8'h11);
    rdc(debug_trigger_pkg::CAP_HIGH_ADDR, 8'h11);
    rdc(debug_trigger_pkg::CAP_LOW_ADDR, 8'h11);
    rdc(debug_trigger_pkg::CAP_HIGH_ADDR, 8'h22);
    rdc(debug_trigger_pkg::STATUS_ADDR, 8'h83);
    $display("test end trace done");
    // manual stop through arm and through enable
    run(8'h00, 8'hd0);
    rdc(debug_trigger_pkg::STATUS_ADDR, 8'h20);
    wr(debug_trigger_pkg::CONTROL_ADDR, 8'h80);
    look(1'b0);
    run(8'h00, 8'hd0);
    wr(debug_trigger_pkg::CONTROL_ADDR, 8'h40);
    look(1'b0);
    rdc(debug_trigger_pkg::STATUS_ADDR, 8'h00);
    $display("test manual stop done");
    // tag type: access alone is not enough, execution is
    run(8'h80, 8'hf0);
    look(1'b1);
    chk({7'h0, break_tag}, 8'h01);
    hit(comp_a, 8'h00, 1'b1);
    m.ev(1'b1, 16'h3000);
    look(1'b1);
    m.ev(1'b1, comp_a);
    look(1'b0);
    $display("test tag done");
    // begin trace: earlier flow words are not kept
    run(8'h40, 8'hd0);
    m.ev(1'b0, 16'h0abc);
    hit(comp_a, 8'h00, 1'b1);
    burst(1'b1);
    rdc(debug_trigger_pkg::STATUS_ADDR, 8'h88);
    rdc(debug_trigger_pkg::CAP_HIGH_ADDR, 8'h40);
    rdc(debug_trigger_pkg::CAP_LOW_ADDR, 8'h00);
    $display("test begin trace done");
    // event-only modes run as begin trace although begin select is clear
    run(8'h03, 8'hd0);
    burst(1'b0);
    rdc(debug_trigger_pkg::STATUS_ADDR, 8'h48);
    for (int i = 0; i < 8; i++) rdc(debug_trigger_pkg::CAP_LOW_ADDR, 8'h30 + 8'(i));
    run(8'h04, 8'hd0);
    m.acc(comp_b, 8'h01);
    m.acc(comp_a, 8'h00);
    burst(1'b0);
    rdc(debug_trigger_pkg::STATUS_ADDR, 8'hc8);
    $display("test event modes done");
    // comparator combinations
    run(8'h01, 8'hd0);
    hit(comp_b, 8'h00, 1'b0);
    rdc(debug_trigger_pkg::STATUS_ADDR, 8'h40);
    run(8'h02, 8'hd0);
    hit(comp_b, 8'h00, 1'b1);
    hit(comp_a, 8'h00, 1'b1);
    hit(comp_b, 8'h00, 1'b0);
    run(8'h05, 8'hd0);
    hit(comp_a, 8'h55, 1'b1);
    hit(comp_a, 8'h00, 1'b0);
    run(8'h06, 8'hd0);
    hit(comp_a, 8'h00, 1'b1);
    hit(comp_a, 8'h55, 1'b0);
    run(8'h07, 8'hd0);
    hit(16'h0fff, 8'h00, 1'b1);
    hit(16'h2001, 8'h00, 1'b1);
    hit(16'h2000, 8'h00, 1'b0);
    run(8'h08, 8'hd0);
    hit(16'h1000, 8'h00, 1'b1);
    hit(16'h2000, 8'h00, 1'b1);
    hit(16'h2001, 8'h00, 1'b0);
    for (int k = 9; k < 16; k++) begin
      run(8'(k), 8'hd0);
      hit(comp_a, 8'h00, 1'b1);
      hit(comp_b, 8'h00, 1'b1);
      hit(16'h1800, 8'h00, 1'b1);
      hit(16'h0000, 8'h00, 1'b1);
    end
    $display("test trigger modes done");
    tally_and_finish();
  end
endmodule : tb_top
